// ### verification/buck_seq_checker_assertions.sv
// Assertions for the dual step-down fault sequencer.
// Bound to its top module; all inputs synchronous to clk.
`timescale 1ns/100ps
module buck_seq_checker
	import buck_seq_pkg::*;
(
	input wire logic       clk,                   // Clock
	input wire logic       rst,                   // Reset
	input wire logic       first_channel_enable,  // Enable 1
	input wire logic       second_channel_enable, // Enable 2
	input wire logic       filtered_bias_supply,  // Bias good
	input wire logic       over_temp,             // Too hot
	input ch_sense_s [1:0] sense,                 // Comparators
	input ch_drive_s [1:0] drive,                 // Drives
	input wire logic [1:0] overvoltage_fault,     // OV latch
	input wire logic [1:0] undervoltage_fault,    // UV latch
	input wire logic       shutdown_mode          // Shutdown
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Run of undervoltage samples on the second channel
	logic [15:0] uvr_q;
	logic [15:0] uvr_d;
	always_comb uvr_d = sense[1].under_volt ? uvr_q + 16'h1 : 16'h0;
	always_ff @(posedge clk) uvr_q <= uvr_d;
	property p_dis;
		!first_channel_enable [*3] |-> drive[0].discharge;
	endproperty
	a_dis: assert property (p_dis) else $error("no discharge");
	property p_ls;
		drive[0].discharge && !overvoltage_fault[0]
			&& !$past(overvoltage_fault[0]) |-> !drive[0].low_side_gate;
	endproperty
	a_ls: assert property (p_ls) else $error("low side on");
	property p_oc;
		sense[0].over_current && !drive[0].high_side_gate
			|=> !drive[0].high_side_gate;
	endproperty
	a_oc: assert property (p_oc) else $error("high side on");
	property p_on;
		drive[0].high_side_gate && sense[0].on_expired
			|=> !drive[0].high_side_gate;
	endproperty
	a_on: assert property (p_on) else $error("on time");
	property p_ov;
		overvoltage_fault[0] && $past(overvoltage_fault[0])
			&& $past(filtered_bias_supply && !over_temp)
			|-> drive[0].low_side_gate && !drive[0].high_side_gate;
	endproperty
	a_ov: assert property (p_ov) else $error("ov drive");
	property p_uvd;
		$rose(undervoltage_fault[1]) |-> uvr_q >= 16'h2ee;
	endproperty
	a_uvd: assert property (p_uvd) else $error("uv early");
	property p_uvx;
		undervoltage_fault[1] && $past(undervoltage_fault[1])
			|-> {drive[0][2:1], drive[1][2:1]} == 4'h0;
	endproperty
	a_uvx: assert property (p_uvx) else $error("uv gates");
	property p_lo;
		!filtered_bias_supply [*3] |-> drive == 6'h09;
	endproperty
	a_lo: assert property (p_lo) else $error("lockout");
	property p_ot;
		over_temp [*3] |-> drive == 6'h09;
	endproperty
	a_ot: assert property (p_ot) else $error("overtemp");
	property p_sd;
		shutdown_mode == !(first_channel_enable || second_channel_enable);
	endproperty
	a_sd: assert property (p_sd) else $error("shutdown");
	c_ov: cover property ($rose(overvoltage_fault[0]));
	c_uv: cover property ($rose(undervoltage_fault[1]));
	c_lo: cover property (!filtered_bias_supply ##1 filtered_bias_supply);
endmodule : buck_seq_checker
bind dual_buck_fault_sequencer buck_seq_checker u_chk (
	.clk, .rst, .first_channel_enable, .second_channel_enable,
	.filtered_bias_supply, .over_temp, .sense, .drive,
	.overvoltage_fault, .undervoltage_fault, .shutdown_mode
);

// ### verification/dual_buck_fault_sequencer_tb.sv
// Self-checking bench for the dual step-down fault sequencer.
// Drives the power stage model; the checker is bound to the top.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dual_buck_fault_sequencer_tb
	import buck_seq_pkg::*;
;
	logic            clk = 1'b0, rst = 1'b1, bias = 1'b1, ot = 1'b0;
	logic            en0 = 1'b0, en1 = 1'b0, lo, sdm;
	logic [1:0]      ov = 2'h0, uv = 2'h0, oc = 2'h0, ovf, uvf;
	logic [31:0]     seed = 32'h05250dc9;
	ch_sense_s [1:0] sense;
	ch_drive_s [1:0] drive;
	logic [15:0]     m, ev;
	logic [15:0]     mq[$];
	logic [15:0]     vq[$];
	wire [CNT_W-1:0] lvl;
	int              n_errors = 0, num_checks = 0, cyc = 0;
	event            look;
	wire [15:0]      obs = {lvl[3:0], sdm, lo, ovf, uvf, drive};
	dual_buck_fault_sequencer #(.UV_BLANK(20), .SS_RAMP(10)) u_dut (
		.clk, .rst, .first_channel_enable(en0),
		.second_channel_enable(en1), .filtered_bias_supply(bias),
		.over_temp(ot), .sense, .drive, .ref_level(lvl),
		.overvoltage_fault(ovf), .undervoltage_fault(uvf),
		.supply_lockout(lo), .shutdown_mode(sdm)
	);
	power_stage_model u_stage (.clk, .drive, .ov, .uv, .oc, .sense);
	always #20 clk = ~clk;
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	// Random valley overcurrent keeps the limiter busy
	task automatic step(int n);
		repeat (n)
		begin
			@(posedge clk);
			seed = xs(seed);
			oc <= seed[1:0] & {2{seed[2]}};
		end
	endtask : step
	// Note masked expectation; ends on a clock edge
	// Optional low nibble of the ramp level in lk and lv
	task automatic chk(logic [11:0] mk, logic [11:0] v,
		logic [3:0] lk = 4'h0, logic [3:0] lv = 4'h0);
		#1;
		mq.push_back({lk, mk});
		vq.push_back({lv, v});
		-> look;
		@(posedge clk);
	endtask : chk
	task automatic wrap_up();
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	always @(look)
	begin
		m = mq.pop_front();
		ev = vq.pop_front();
		`CHK(obs & m, ev)
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	initial
	begin
		step(8);
		rst <= 1'b0;
		step(1);
		chk(12'hfff, 12'h809);
		en0 <= 1'b1;
		en1 <= 1'b1;
		step(4);
		chk(12'h809, 12'h000);
		en0 <= 1'b0;
		en1 <= 1'b0;
		step(4);
		chk(12'hfff, 12'h809);
		en0 <= 1'b1;
		step(3);
		en1 <= 1'b1;
		step(4);
		chk(12'h030, 12'h000);
		step(20);
		chk(12'h009, 12'h000, 4'hf, 4'h9);
		ov <= 2'h1;
		step(3);
		ov <= 2'h0;
		step(5);
		chk(12'h3c7, 12'h103);
		en0 <= 1'b0;
		step(4);
		chk(12'h301, 12'h001);
		en0 <= 1'b1;
		step(30);
		uv <= 2'h2;
		step(700);
		uv <= 2'h0;
		step(3);
		chk(12'h0c0, 12'h000);
		en1 <= 1'b0;
		step(4);
		en1 <= 1'b1;
		uv <= 2'h2;
		step(765);
		chk(12'h0c0, 12'h000);
		step(14);
		chk(12'h0f6, 12'h080);
		uv <= 2'h0;
		en0 <= 1'b0;
		en1 <= 1'b0;
		step(4);
		chk(12'hfff, 12'h809);
		en0 <= 1'b1;
		en1 <= 1'b1;
		step(30);
		bias <= 1'b0;
		step(3);
		chk(12'h43f, 12'h409);
		bias <= 1'b1;
		step(30);
		chk(12'h409, 12'h000);
		ot <= 1'b1;
		step(3);
		chk(12'h03f, 12'h009);
		ot <= 1'b0;
		step(30);
		chk(12'h009, 12'h000);
		en0 <= 1'b0;
		en1 <= 1'b0;
		step(4);
		chk(12'hfff, 12'h809);
		wrap_up();
	end
endmodule : dual_buck_fault_sequencer_tb

// ### verification/power_stage_model.sv
// Power stage and comparator model for both channels.
// Bench forces OV, UV and overcurrent; on and off times are modelled.
`timescale 1ns/100ps
module power_stage_model
	import buck_seq_pkg::*;
(
	input wire logic        clk,   // Clock
	input ch_drive_s [1:0]  drive, // Gate drives
	input wire logic [1:0]  ov,    // Force overvoltage
	input wire logic [1:0]  uv,    // Force undervoltage
	input wire logic [1:0]  oc,    // Force overcurrent
	output ch_sense_s [1:0] sense  // Comparators
);
	logic [1:0] hs_q     = 2'h0;
	logic [3:0] t_q [2]  = '{4'h0, 4'h0};
	// Cycles since the high side last changed, saturating
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			hs_q[i] <= drive[i].high_side_gate;
			if (hs_q[i] !== drive[i].high_side_gate)
				t_q[i] <= 4'h0;
			else if (t_q[i] != 4'hf)
				t_q[i] <= t_q[i] + 4'h1;
		end
	end
	always_comb
	begin
		for (int i = 0; i < 2; i++)
			sense[i] = {ov[i], uv[i], oc[i], !hs_q[i] && t_q[i] > 4'h1,
				hs_q[i] && t_q[i] > 4'h2};
	end
endmodule : power_stage_model

// ### verilog/buck_seq_pkg.sv
// Package for the dual step-down fault sequencer.
// Assumes a single 25 MHz clock; all inputs synchronous to it.
package buck_seq_pkg;

	localparam int unsigned CLK_PERIOD_NS  = 40;
	// Undervoltage delay, 30 us, rounded down to whole cycles
	localparam int unsigned UV_DELAY_NS    = 30000;
	localparam int unsigned UV_DELAY_CYC   = UV_DELAY_NS / CLK_PERIOD_NS;
	// Undervoltage enable blanking, 2.0 ms
	localparam int unsigned UV_BLANK_US    = 2000;
	localparam int unsigned UV_BLANK_CYC   = UV_BLANK_US * 1000 / CLK_PERIOD_NS;
	// Soft start ramp, 1.2 ms
	localparam int unsigned SS_TIME_US     = 1200;
	localparam int unsigned SS_CYC         = SS_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CNT_W          = 17;

	typedef enum logic [4:0] {
		CH_OFF     = 5'b00001,
		CH_WAIT    = 5'b00010,
		CH_RAMP    = 5'b00100,
		CH_RUN     = 5'b01000,
		CH_LATCHED = 5'b10000
	} ch_state_e;

	// Analog comparator results for one channel
	typedef struct packed {
		logic over_volt;    // Feedback above 115 %
		logic under_volt;   // Feedback below 70 %
		logic over_current; // Valley current above trip level
		logic need_on;      // Feedback says output insufficient
		logic on_expired;   // On-time one-shot has run out
	} ch_sense_s;

	// Gate and discharge drive for one channel
	typedef struct packed {
		logic high_side_gate;
		logic low_side_gate;
		logic discharge;
	} ch_drive_s;

endpackage : buck_seq_pkg

// ### verilog/dual_buck_fault_sequencer.sv
// Dual step-down controller sequencing and protection logic.
// Assumes comparator inputs are already synchronous to clk.
`timescale 1ns/100ps
// Summary of operation
// - Discharge output when enable is low or any protection has stopped it.
// - Discharge uses internal switch; low-side gate stays off meanwhile except in overvoltage latch.
// - Current compared only with high side off; off state extended while high.
// - Overvoltage latches channel with high side off and low side on.
// - Undervoltage starts 30 us counter; on expiry both gates latch off.
// - Undervoltage latch on one channel forces other channel gates off unless that channel holds an overvoltage latch.
// - Undervoltage detection blanked for 2.0 ms after the channel enters its ramp.
// - Supply lockout shuts everything off, not latched, resumes on clear.
// - Overtemperature drives gates low, discharges, restarts when clear.
// - Shutdown mode while both enables low, normal mode otherwise.
// - Enable rise ramps reference 1.2 ms; waits if other channel ramping.
// - Simultaneous enables start both ramps together.
// - High side on, off at one-shot expiry, on again when output low.
module dual_buck_fault_sequencer
	import buck_seq_pkg::*;
#(
	parameter int unsigned UV_BLANK = UV_BLANK_CYC,
	parameter int unsigned SS_RAMP  = SS_CYC
)(
	input  wire logic             clk,                  // Clock
	input  wire logic             rst,                  // Sync reset
	input  wire logic             first_channel_enable, // Channel 1 enable
	input  wire logic             second_channel_enable,// Channel 2 enable
	input  wire logic             filtered_bias_supply, // Bias supply good
	input  wire logic             over_temp,            // Overtemperature
	input  ch_sense_s [1:0]       sense,                // Comparators
	output ch_drive_s [1:0]       drive,                // Gate/discharge
	output logic [CNT_W-1:0]      ref_level,            // Shared ramp
	output logic [1:0]            overvoltage_fault,    // Latched OV
	output logic [1:0]            undervoltage_fault,   // Latched UV
	output logic                  supply_lockout,       // Lockout active
	output logic                  shutdown_mode         // Both disabled
);
	ch_state_e [1:0]  st_q, st_d;
	logic [1:0]       en;
	logic [1:0]       ov_q, ov_d, uv_q, uv_d, uv_trip;
	logic [1:0]       hs_q, hs_d, ls_q, ls_d, dis_q, dis_d;
	logic [1:0]       ramp_owner_q, ramp_owner_d;
	logic             halt;
	logic             ss_start, ss_busy, ss_done;
	logic [CNT_W-1:0] ss_level;

	assign en      = {second_channel_enable, first_channel_enable};
	assign halt    = !filtered_bias_supply || over_temp;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_uv
			uv_delay_timer #(
				.DELAY_CYC (UV_DELAY_CYC),
				.BLANK_CYC (UV_BLANK)
			) u_uv (
				.clk        (clk),
				.rst        (rst),
				.clear      (!(st_q[g] inside {CH_RAMP, CH_RUN}) || halt),
				.under_volt (sense[g].under_volt),
				.uv_trip    (uv_trip[g])
			);
		end
	endgenerate

	soft_start_dac #(
		.RAMP_CYC (SS_RAMP)
	) u_ss (
		.clk   (clk),
		.rst   (rst),
		.start (ss_start),
		// A shared ramp keeps running while any owner is still enabled and halt is low
		.abort (halt || (ramp_owner_q != 2'b00
			&& (ramp_owner_q & en) == 2'b00)),
		.level (ss_level),
		.busy  (ss_busy),
		.done  (ss_done)
	);

	// Channel sequencing and fault latches
	always_comb
	begin
		st_d         = st_q;
		ov_d         = ov_q;
		uv_d         = uv_q;
		ramp_owner_d = ramp_owner_q;
		ss_start     = 1'b0;
		if (ss_done || !ss_busy)
			ramp_owner_d = 2'b00;
		for (int i = 0; i < 2; i++)
		begin
			if (!en[i])
			begin
				st_d[i] = CH_OFF;
				ov_d[i] = 1'b0;
				uv_d[i] = 1'b0;
			end
			else if (ov_q[i] || uv_q[i] || uv_q[1-i])
				st_d[i] = CH_LATCHED;
			else if (sense[i].over_volt &&
				st_q[i] inside {CH_RAMP, CH_RUN} && !halt)
			begin
				ov_d[i] = 1'b1;
				st_d[i] = CH_LATCHED;
			end
			else if (uv_trip[i] && !halt)
			begin
				uv_d[i] = 1'b1;
				st_d[i] = CH_LATCHED;
			end
			else if (halt)
				st_d[i] = CH_WAIT;
			else
				unique case (st_q[i])
					CH_OFF, CH_WAIT:
						if (!ss_busy || (ss_done && ramp_owner_q[i])
							|| ramp_owner_d[i])
						begin
							st_d[i] = CH_RAMP;
							ramp_owner_d[i] = 1'b1;
						end
					CH_RAMP:
						if (ss_done)
							st_d[i] = CH_RUN;
					CH_RUN, CH_LATCHED: ;
				endcase
		end
		// Two channels admitted in one cycle share a single ramp
		if (ramp_owner_d != 2'b00 && (!ss_busy || ss_done))
			ss_start = 1'b1;
		if (ss_busy && !ss_done)
			ramp_owner_d = ramp_owner_q;
		// A channel waiting behind a running ramp joins only the next one
		for (int i = 0; i < 2; i++)
			if (st_d[i] == CH_RAMP && st_q[i] != CH_RAMP && !ss_start)
				st_d[i] = CH_WAIT;
	end

	// Gate drive: valley current limit and on-time control
	always_comb
	begin
		hs_d  = hs_q;
		ls_d  = ls_q;
		dis_d = dis_q;
		for (int i = 0; i < 2; i++)
		begin
			if (ov_q[i] && !halt)
			begin
				hs_d[i]  = 1'b0;
				ls_d[i]  = 1'b1;
				dis_d[i] = 1'b1;
			end
			else if (st_q[i] inside {CH_RAMP, CH_RUN} && !halt
				&& uv_q == 2'b00)
			begin
				dis_d[i] = 1'b0;
				if (hs_q[i])
				begin
					if (sense[i].on_expired)
					begin
						hs_d[i] = 1'b0;
						ls_d[i] = 1'b1;
					end
				end
				else if (sense[i].need_on && !sense[i].over_current)
				begin
					hs_d[i] = 1'b1;
					ls_d[i] = 1'b0;
				end
				else
					ls_d[i] = 1'b1;
			end
			else
			begin
				hs_d[i]  = 1'b0;
				ls_d[i]  = 1'b0;
				dis_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q         <= '{CH_OFF, CH_OFF};
			ov_q         <= 2'b00;
			uv_q         <= 2'b00;
			hs_q         <= 2'b00;
			ls_q         <= 2'b00;
			dis_q        <= 2'b11;
			ramp_owner_q <= 2'b00;
		end
		else
		begin
			st_q         <= st_d;
			ov_q         <= ov_d;
			uv_q         <= uv_d;
			hs_q         <= hs_d;
			ls_q         <= ls_d;
			dis_q        <= dis_d;
			ramp_owner_q <= ramp_owner_d;
		end
	end

	generate
		for (g = 0; g < 2; g++)
		begin : g_out
			assign drive[g].high_side_gate = hs_q[g];
			assign drive[g].low_side_gate  = ls_q[g];
			assign drive[g].discharge      = dis_q[g];
		end
	endgenerate

	assign ref_level          = ss_level;
	assign overvoltage_fault  = ov_q;
	assign undervoltage_fault = uv_q;
	assign supply_lockout     = !filtered_bias_supply;
	assign shutdown_mode      = (en == 2'b00);

endmodule : dual_buck_fault_sequencer

// ### verilog/soft_start_dac.sv
// Shared soft-start ramp counter used by both channels.
// Assumes start is a one-cycle pulse from the sequencer.
`timescale 1ns/100ps
module soft_start_dac
	import buck_seq_pkg::*;
#(
	parameter int unsigned RAMP_CYC = SS_CYC
)(
	input  wire logic             clk,   // Clock
	input  wire logic             rst,   // Synchronous reset
	input  wire logic             start, // Begin a ramp
	input  wire logic             abort, // Stop ramp
	output logic [CNT_W-1:0]      level, // Reference ramp value
	output logic                  busy,  // Ramp in progress
	output logic                  done   // Pulse at ramp end
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             busy_q, busy_d;
	logic             done_q, done_d;

	assign level = cnt_q;
	assign busy  = busy_q;
	assign done  = done_q;

	always_comb
	begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (abort)
		begin
			busy_d = 1'b0;
			cnt_d  = '0;
		end
		else if (start)
		begin
			busy_d = 1'b1;
			cnt_d  = '0;
		end
		else if (busy_q)
		begin
			if (cnt_q == CNT_W'(RAMP_CYC - 1))
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

endmodule : soft_start_dac

// ### verilog/uv_delay_timer.sv
// Undervoltage delay and startup blanking for one channel.
// Assumes clear is held while the channel is not running.
`timescale 1ns/100ps
module uv_delay_timer
	import buck_seq_pkg::*;
#(
	parameter int unsigned DELAY_CYC = UV_DELAY_CYC,
	parameter int unsigned BLANK_CYC = UV_BLANK_CYC
)(
	input  wire logic clk,        // Clock
	input  wire logic rst,        // Synchronous reset
	input  wire logic clear,      // Channel not running
	input  wire logic under_volt, // Undervoltage comparator
	output logic      uv_trip     // Pulse when the delay expires
);
	logic [CNT_W-1:0] blank_q, blank_d;
	logic [CNT_W-1:0] delay_q, delay_d;
	logic             trip_q, trip_d;
	logic             armed;

	assign armed   = (blank_q == CNT_W'(BLANK_CYC));
	assign uv_trip = trip_q;

	always_comb
	begin
		blank_d = blank_q;
		delay_d = delay_q;
		trip_d  = 1'b0;
		if (clear)
		begin
			blank_d = '0;
			delay_d = '0;
		end
		else
		begin
			if (!armed)
				blank_d = blank_q + CNT_W'(1);
			if (!armed || !under_volt)
				delay_d = '0;
			else if (delay_q == CNT_W'(DELAY_CYC - 1))
			begin
				trip_d  = 1'b1;
				delay_d = '0;
			end
			else
				delay_d = delay_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			blank_q <= '0;
			delay_q <= '0;
			trip_q  <= 1'b0;
		end
		else
		begin
			blank_q <= blank_d;
			delay_q <= delay_d;
			trip_q  <= trip_d;
		end
	end

endmodule : uv_delay_timer
